// [hdl/eag_top.sv]
// effective address generator: address modes, indirection and block move
// Summary of operation
// (RULE1) register fields pick one of eight data or eight address registers
// (RULE2) byte or word short displacement is sign-extended and added
// (RULE3) index from data or address register is scaled by 1, 2, 4 or 8
// (RULE4) base displacement is signed, 16 or 32 bits, and added
// (RULE5) outer displacement is added only after the indirect fetch completes
// (RULE6) memory-indirect modes read a long word used as the next pointer
// (RULE7) immediate operand comes from extension words, 8, 16 or 32 bits
// (RULE8) block move transfers one aligned sixteen-byte block as one operation
// (RULE9) pre-indexed forms add the scaled index before the fetch
// (RULE10) post-indexed forms add the scaled index after the fetch
// (RULE11) postincrement and predecrement update the address register
// (RULE12) word index is sign-extended; all sums wrap at 32 bits
`timescale 1ns/1ps
module eag_top
  import eag_pkg::*;
(
  input wire logic ref_clk,
  input wire logic nrst,
  input wire logic req_valid,
  input wire logic [3:0] ea_mode,
  input wire logic [1:0] op_size,
  input wire logic [2:0] data_register_sel,
  input wire logic [2:0] address_register_sel,
  input wire logic [3:0] index_register_sel,
  input wire logic index_long,
  input wire logic [1:0] index_scale,
  input wire logic base_is_pc,
  input wire logic [31:0] program_counter,
  input wire logic [7:0] short_disp_byte,
  input wire logic [15:0] short_disp_word,
  input wire logic [31:0] base_displacement,
  input wire logic base_disp_long,
  input wire logic [31:0] outer_displacement,
  input wire logic outer_disp_long,
  input wire logic [31:0] ext_words,
  input wire logic mem_rd_ack,
  input wire logic [31:0] mem_rd_data,
  input wire logic block_move_done,
  input wire logic rf_wr_en,
  input wire logic [3:0] rf_wr_sel,
  input wire logic [31:0] rf_wr_data,
  output logic busy_ff,
  output logic done_ff,
  output logic [31:0] ea_result_ff,
  output logic mem_rd_req_ff,
  output logic [31:0] mem_rd_addr_ff,
  output logic block_move_req_ff,
  output logic [31:0] block_move_src_ff,
  output logic [31:0] block_move_dst_ff
);
  eag_rf_if rf ();
  eag_regfile u_regs (.ref_clk(ref_clk), .nrst(nrst), .rf(rf));

  eag_state_t state_ff;
  eag_mode_t mode_ff;
  logic [1:0] size_ff;
  logic [2:0] dsel_ff, asel_ff;
  logic [3:0] xsel_ff;
  logic xlong_ff, pc_base_ff, bd_long_ff, od_long_ff;
  logic [1:0] scale_ff;
  logic [31:0] pc_ff, bd_ff, od_ff, ext_ff, scaled_ff;
  logic [7:0] d8_ff;
  logic [15:0] d16_ff;
  logic fetched_ff;

  logic accept;
  logic [31:0] base_v, idx_ext, scaled, bd_ext, od_ext, step, calc_sum, imm_v, outer_sum;
  logic is_mem;

  assign accept = req_valid && state_ff == EAG_ST_IDLE;
  assign is_mem = mode_ff == EAG_MEM_PRE || mode_ff == EAG_MEM_POST;

  // (RULE1) operand or base register select
  assign rf.base_sel = (mode_ff == EAG_DATA_DIR) ? {1'b0, dsel_ff} : {1'b1, asel_ff};
  assign rf.idx_sel = xsel_ff;
  assign rf.ext_wr_en = rf_wr_en;
  assign rf.ext_wr_sel = rf_wr_sel;
  assign rf.ext_wr_data = rf_wr_data;

  always_comb begin
    base_v = pc_base_ff ? pc_ff : rf.base_val;
    // (RULE12) word index sign-extended
    idx_ext = xlong_ff ? rf.idx_val : {{16{rf.idx_val[15]}}, rf.idx_val[15:0]};
    // (RULE3) index scaling
    scaled = idx_ext << index_shift(scale_ff);
    // (RULE4) signed base displacement
    bd_ext = bd_long_ff ? bd_ff : {{16{bd_ff[15]}}, bd_ff[15:0]};
    // (RULE5) signed outer displacement
    od_ext = od_long_ff ? od_ff : {{16{od_ff[15]}}, od_ff[15:0]};
    // a7 byte steps keep the stack word aligned
    step = (size_ff == EAG_SIZE_LONG) ? EAG_INC_LONG :
           (size_ff == EAG_SIZE_WORD || asel_ff == EAG_STACK_REG) ? EAG_INC_WORD :
           EAG_INC_BYTE;
    // (RULE7) immediate width follows operand size
    imm_v = (size_ff == EAG_SIZE_BYTE) ? {24'h00_0000, ext_ff[7:0]} :
            (size_ff == EAG_SIZE_WORD) ? {16'h0000, ext_ff[15:0]} : ext_ff;
    case (mode_ff)
      EAG_DATA_DIR, EAG_ADDR_DIR, EAG_IND, EAG_POSTINC: calc_sum = rf.base_val;
      // (RULE11) predecrement result
      EAG_PREDEC: calc_sum = rf.base_val - step;
      // (RULE2) word displacement
      EAG_DISP16: calc_sum = base_v + {{16{d16_ff[15]}}, d16_ff};
      // (RULE2) byte displacement with index
      EAG_INDEX8: calc_sum = base_v + {{24{d8_ff[7]}}, d8_ff} + scaled;
      // (RULE9) index joins the sum before the fetch
      EAG_INDEX_BD, EAG_MEM_PRE: calc_sum = base_v + bd_ext + scaled;
      EAG_MEM_POST: calc_sum = base_v + bd_ext;
      EAG_ABS_W: calc_sum = {{16{ext_ff[15]}}, ext_ff[15:0]};
      EAG_ABS_L: calc_sum = ext_ff;
      EAG_IMM: calc_sum = imm_v;
      default: calc_sum = rf.base_val;
    endcase
    // (RULE10) post-indexed adds index after the fetch
    outer_sum = mem_rd_data + od_ext + ((mode_ff == EAG_MEM_POST) ? scaled_ff : 32'h0000_0000);
  end

  function automatic logic [4:0] index_shift(input logic [1:0] s);
    index_shift = {3'h0, s};
  endfunction : index_shift

  // request capture
  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      mode_ff <= EAG_DATA_DIR;
      size_ff <= EAG_SIZE_BYTE;
      dsel_ff <= 3'h0;
      asel_ff <= 3'h0;
      xsel_ff <= 4'h0;
      xlong_ff <= 1'b0;
      scale_ff <= 2'h0;
      pc_base_ff <= 1'b0;
      pc_ff <= EAG_WORD_RST;
      bd_ff <= EAG_WORD_RST;
      bd_long_ff <= 1'b0;
      od_ff <= EAG_WORD_RST;
      od_long_ff <= 1'b0;
      ext_ff <= EAG_WORD_RST;
      d8_ff <= 8'h00;
      d16_ff <= 16'h0000;
    end else if (accept) begin
      mode_ff <= eag_mode_t'(ea_mode);
      size_ff <= op_size;
      dsel_ff <= data_register_sel;
      asel_ff <= address_register_sel;
      xsel_ff <= index_register_sel;
      xlong_ff <= index_long;
      scale_ff <= index_scale;
      pc_base_ff <= base_is_pc;
      pc_ff <= program_counter;
      bd_ff <= base_displacement;
      bd_long_ff <= base_disp_long;
      od_ff <= outer_displacement;
      od_long_ff <= outer_disp_long;
      ext_ff <= ext_words;
      d8_ff <= short_disp_byte;
      d16_ff <= short_disp_word;
    end
  end

  // (RULE11) address register update on post/pre modes
  assign rf.upd_en = state_ff == EAG_ST_CALC && (mode_ff == EAG_POSTINC || mode_ff == EAG_PREDEC);
  assign rf.upd_sel = asel_ff;
  assign rf.upd_val = (mode_ff == EAG_POSTINC) ? rf.base_val + step : rf.base_val - step;

  // sequencing
  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      state_ff <= EAG_ST_IDLE;
      busy_ff <= 1'b0;
      done_ff <= 1'b0;
      ea_result_ff <= EAG_WORD_RST;
      mem_rd_req_ff <= 1'b0;
      mem_rd_addr_ff <= EAG_WORD_RST;
      block_move_req_ff <= 1'b0;
      block_move_src_ff <= EAG_WORD_RST;
      block_move_dst_ff <= EAG_WORD_RST;
      scaled_ff <= EAG_WORD_RST;
      fetched_ff <= 1'b0;
    end else begin
      done_ff <= 1'b0;
      case (state_ff)
        EAG_ST_IDLE: begin
          if (accept) begin
            state_ff <= EAG_ST_CALC;
            busy_ff <= 1'b1;
            fetched_ff <= 1'b0;
          end
        end
        EAG_ST_CALC: begin
          scaled_ff <= scaled;
          if (is_mem) begin
            // (RULE6) fetch the pointer long word
            mem_rd_req_ff <= 1'b1;
            mem_rd_addr_ff <= calc_sum;
            state_ff <= EAG_ST_FETCH;
          end else if (mode_ff == EAG_BLOCK_MOVE) begin
            // (RULE8) whole aligned sixteen-byte block
            block_move_req_ff <= 1'b1;
            block_move_src_ff <= {rf.base_val[31:EAG_BLOCK_ALIGN_BITS],
                                  {EAG_BLOCK_ALIGN_BITS{1'b0}}};
            block_move_dst_ff <= {rf.idx_val[31:EAG_BLOCK_ALIGN_BITS],
                                  {EAG_BLOCK_ALIGN_BITS{1'b0}}};
            state_ff <= EAG_ST_MOVE;
          end else begin
            ea_result_ff <= calc_sum;
            done_ff <= 1'b1;
            busy_ff <= 1'b0;
            state_ff <= EAG_ST_IDLE;
          end
        end
        EAG_ST_FETCH: begin
          // (RULE5) outer step waits for the fetched pointer
          if (mem_rd_ack) begin
            mem_rd_req_ff <= 1'b0;
            fetched_ff <= 1'b1;
            ea_result_ff <= outer_sum;
            done_ff <= 1'b1;
            busy_ff <= 1'b0;
            state_ff <= EAG_ST_IDLE;
          end
        end
        EAG_ST_MOVE: begin
          if (block_move_done) begin
            block_move_req_ff <= 1'b0;
            done_ff <= 1'b1;
            busy_ff <= 1'b0;
            state_ff <= EAG_ST_IDLE;
          end
        end
        default: begin
          state_ff <= EAG_ST_IDLE;
          busy_ff <= 1'b0;
        end
      endcase
    end
  end

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!nrst);

  a_fetch_req_held: assert property (mem_rd_req_ff && !mem_rd_ack |=> mem_rd_req_ff) // RULE6
    else $error("indirect fetch request dropped before ack");
  a_fetch_addr_stable: assert property ( // RULE9
    mem_rd_req_ff && $past(mem_rd_req_ff) |-> $stable(mem_rd_addr_ff))
    else $error("fetch address changed while pending");
  a_outer_after_fetch: assert property (done_ff && is_mem |-> fetched_ff) // RULE5
    else $error("indirect result finished without fetch");
  a_block_aligned: assert property ( // RULE8
    block_move_req_ff
    |-> block_move_src_ff[3:0] == 4'h0 && block_move_dst_ff[3:0] == 4'h0)
    else $error("block move address not sixteen-byte aligned");
  a_move_held: assert property ( // RULE8
    block_move_req_ff && !block_move_done |=> block_move_req_ff && busy_ff)
    else $error("block move abandoned before done");
  a_imm_byte_width: assert property ( // RULE7
    done_ff && mode_ff == EAG_IMM && size_ff == EAG_SIZE_BYTE
    |-> ea_result_ff[31:8] == 24'h00_0000)
    else $error("byte immediate wider than eight bits");
  a_direct_latency: assert property ( // RULE1
    accept && ea_mode == 4'(EAG_DATA_DIR)
    |=> ##1 done_ff && ea_result_ff == $past(rf.base_val))
    else $error("register direct result late or wrong");
  a_disp_signed: assert property ( // RULE2
    state_ff == EAG_ST_CALC && mode_ff == EAG_DISP16 && !pc_base_ff
    |=> ea_result_ff == $past(rf.base_val) + {{16{$past(d16_ff[15])}}, $past(d16_ff)})
    else $error("word displacement not sign-extended");
  a_done_pulse: assert property (done_ff |=> !done_ff) // RULE12
    else $error("done held longer than one cycle");

  c_mem_post: cover property (done_ff && mode_ff == EAG_MEM_POST);
  c_mem_pre: cover property (done_ff && mode_ff == EAG_MEM_PRE);
  c_block: cover property (block_move_req_ff ##[1:20] done_ff);
  c_predec: cover property (rf.upd_en && mode_ff == EAG_PREDEC);
endmodule : eag_top

// [hdl/eag_pkg.sv]
// shared constants and types for the effective address generator
package eag_pkg;
  localparam int EAG_NUM_REGS = 16;
  localparam logic [31:0] EAG_REG_RST = 32'h0000_0000;
  localparam logic [31:0] EAG_WORD_RST = 32'h0000_0000;
  localparam int EAG_BLOCK_ALIGN_BITS = 4;
  localparam logic [31:0] EAG_INC_BYTE = 32'h0000_0001;
  localparam logic [31:0] EAG_INC_WORD = 32'h0000_0002;
  localparam logic [31:0] EAG_INC_LONG = 32'h0000_0004;
  localparam logic [2:0] EAG_STACK_REG = 3'h7;
  localparam logic [1:0] EAG_SIZE_BYTE = 2'h0;
  localparam logic [1:0] EAG_SIZE_WORD = 2'h1;
  localparam logic [1:0] EAG_SIZE_LONG = 2'h2;

  typedef enum logic [3:0] {
    EAG_DATA_DIR, EAG_ADDR_DIR, EAG_IND, EAG_POSTINC, EAG_PREDEC, EAG_DISP16,
    EAG_INDEX8, EAG_INDEX_BD, EAG_MEM_PRE, EAG_MEM_POST, EAG_ABS_W, EAG_ABS_L,
    EAG_IMM, EAG_BLOCK_MOVE
  } eag_mode_t;

  typedef enum logic [2:0] {
    EAG_ST_IDLE, EAG_ST_CALC, EAG_ST_FETCH, EAG_ST_OUTER, EAG_ST_MOVE
  } eag_state_t;
endpackage : eag_pkg

// [hdl/eag_rf_if.sv]
// register file access between the address datapath and its register file
`timescale 1ns/1ps
interface eag_rf_if;
  logic [3:0] base_sel;
  logic [31:0] base_val;
  logic [3:0] idx_sel;
  logic [31:0] idx_val;
  logic upd_en;
  logic [2:0] upd_sel;
  logic [31:0] upd_val;
  logic ext_wr_en;
  logic [3:0] ext_wr_sel;
  logic [31:0] ext_wr_data;
  modport datapath (output base_sel, idx_sel, upd_en, upd_sel, upd_val,
                    output ext_wr_en, ext_wr_sel, ext_wr_data,
                    input base_val, idx_val);
  modport regs (input base_sel, idx_sel, upd_en, upd_sel, upd_val,
                input ext_wr_en, ext_wr_sel, ext_wr_data,
                output base_val, idx_val);
endinterface : eag_rf_if

// [hdl/eag_regfile.sv]
// eight data and eight address registers, two read ports, two write ports
`timescale 1ns/1ps
module eag_regfile
  import eag_pkg::*;
(
  input wire logic ref_clk,
  input wire logic nrst,
  eag_rf_if.regs rf
);
  // index 0..7 data registers, 8..15 address registers
  logic [31:0] regs_ff [EAG_NUM_REGS];

  always_ff @(posedge ref_clk) begin
    for (int i = 0; i < EAG_NUM_REGS; i++) begin
      if (!nrst) begin
        regs_ff[i] <= EAG_REG_RST;
      end else if (rf.ext_wr_en && rf.ext_wr_sel == 4'(i)) begin
        // software-visible writeback wins over the mode update
        regs_ff[i] <= rf.ext_wr_data;
      end else if (rf.upd_en && {1'b1, rf.upd_sel} == 4'(i)) begin
        regs_ff[i] <= rf.upd_val;
      end
    end
  end

  assign rf.base_val = regs_ff[rf.base_sel];
  assign rf.idx_val = regs_ff[rf.idx_sel];
endmodule : eag_regfile

// [bench/test_effective_address_generator.sv]
// self-checking bench for the effective address generator
`timescale 1ns/1ps
module test_effective_address_generator;
  import eag_pkg::*;
  logic ref_clk, nrst, req_valid, index_long, base_is_pc, base_disp_long, outer_disp_long;
  logic mem_rd_ack, block_move_done, rf_wr_en, busy_ff, done_ff, mem_rd_req_ff;
  logic block_move_req_ff;
  logic [3:0] ea_mode, index_register_sel, rf_wr_sel;
  logic [1:0] op_size, index_scale;
  logic [2:0] data_register_sel, address_register_sel;
  logic [7:0] short_disp_byte;
  logic [15:0] short_disp_word;
  logic [31:0] program_counter, base_displacement, outer_displacement, ext_words;
  logic [31:0] mem_rd_data, rf_wr_data, ea_result_ff, mem_rd_addr_ff;
  logic [31:0] block_move_src_ff, block_move_dst_ff, res, ptr, exp_addr, exp_src, exp_dst;
  int num_errors, num_checks, stall;

  eag_top dut (.ref_clk(ref_clk), .nrst(nrst), .req_valid(req_valid), .ea_mode(ea_mode),
    .op_size(op_size), .data_register_sel(data_register_sel),
    .address_register_sel(address_register_sel), .index_register_sel(index_register_sel),
    .index_long(index_long), .index_scale(index_scale), .base_is_pc(base_is_pc),
    .program_counter(program_counter), .short_disp_byte(short_disp_byte),
    .short_disp_word(short_disp_word), .base_displacement(base_displacement),
    .base_disp_long(base_disp_long), .outer_displacement(outer_displacement),
    .outer_disp_long(outer_disp_long), .ext_words(ext_words), .mem_rd_ack(mem_rd_ack),
    .mem_rd_data(mem_rd_data), .block_move_done(block_move_done), .rf_wr_en(rf_wr_en),
    .rf_wr_sel(rf_wr_sel), .rf_wr_data(rf_wr_data), .busy_ff(busy_ff), .done_ff(done_ff),
    .ea_result_ff(ea_result_ff), .mem_rd_req_ff(mem_rd_req_ff),
    .mem_rd_addr_ff(mem_rd_addr_ff), .block_move_req_ff(block_move_req_ff),
    .block_move_src_ff(block_move_src_ff), .block_move_dst_ff(block_move_dst_ff));

  initial begin
    ref_clk = 1'b0;
    forever #25 ref_clk = ~ref_clk;
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    num_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("wrong value at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask : chk

  task close_out;
    $display("checks %0d errors %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : close_out

  task automatic wr_reg(input logic [3:0] sel, input logic [31:0] val);
    rf_wr_en = 1'b1;
    rf_wr_sel = sel;
    rf_wr_data = val;
    @(negedge ref_clk);
    rf_wr_en = 1'b0;
    @(negedge ref_clk);
  endtask : wr_reg

  // one request; answers a fetch or block move after stall cycles
  task automatic go(input eag_mode_t m);
    int n;
    int st;
    logic [31:0] exp_n;
    st = stall;
    ea_mode = m;
    req_valid = 1'b1;
    mem_rd_data = ~ptr;
    @(negedge ref_clk);
    req_valid = 1'b0;
    n = 1;
    while (done_ff !== 1'b1 && n < 40) begin
      if (mem_rd_ack || block_move_done) begin
        mem_rd_ack = 1'b0;
        block_move_done = 1'b0;
        mem_rd_data = ~ptr;
      end else if (mem_rd_req_ff === 1'b1 || block_move_req_ff === 1'b1) begin
        if (st == 0 && mem_rd_req_ff === 1'b1) begin
          chk(mem_rd_addr_ff, exp_addr, "fetch address");
          mem_rd_ack = 1'b1;
          mem_rd_data = ptr;
        end else if (st == 0) begin
          chk(block_move_src_ff, exp_src, "move source");
          chk(block_move_dst_ff, exp_dst, "move destination");
          block_move_done = 1'b1;
        end
        st--;
      end
      @(negedge ref_clk);
      n++;
    end
    mem_rd_ack = 1'b0;
    block_move_done = 1'b0;
    res = ea_result_ff;
    // memory and move forms finish only after their answer
    exp_n = (m inside {EAG_MEM_PRE, EAG_MEM_POST, EAG_BLOCK_MOVE}) ? 32'(3 + stall) : 32'h2;
    chk(32'(n), exp_n, "done timing");
    chk(32'({busy_ff, mem_rd_req_ff, block_move_req_ff}), 32'h0, "request left up");
  endtask : go

  task t_direct;
    data_register_sel = 3'h3;
    go(EAG_DATA_DIR);
    chk(res, 32'h1234_5678, "data direct");
    address_register_sel = 3'h2;
    go(EAG_ADDR_DIR);
    chk(res, 32'h1000_0000, "address direct");
  endtask : t_direct

  task t_disp;
    short_disp_word = 16'hfffe;
    go(EAG_DISP16);
    chk(res, 32'h0fff_fffe, "negative word disp");
    address_register_sel = 3'h6;
    short_disp_word = 16'h0020;
    go(EAG_DISP16);
    chk(res, 32'h0000_0010, "wrapping sum");
    address_register_sel = 3'h2;
  endtask : t_disp

  task t_index;
    index_register_sel = 4'h3;
    index_long = 1'b1;
    short_disp_byte = 8'h04;
    for (int s = 0; s < 4; s++) begin
      index_scale = 2'(s);
      go(EAG_INDEX8);
      chk(res, 32'h1000_0004 + (32'h1234_5678 << s), "scaled index");
    end
    index_register_sel = 4'h5;
    index_long = 1'b0;
    short_disp_byte = 8'h80;
    go(EAG_INDEX8);
    chk(res, 32'h0ffb_ff98, "word index, negative byte disp");
  endtask : t_index

  task t_base_disp;
    base_is_pc = 1'b1;
    program_counter = 32'h0000_4000;
    index_register_sel = 4'hf;
    index_long = 1'b1;
    index_scale = 2'h1;
    base_displacement = 32'hdead_8000;
    go(EAG_INDEX_BD);
    chk(res, 32'h0000_0000, "word base disp");
    base_disp_long = 1'b1;
    go(EAG_INDEX_BD);
    chk(res, 32'hdeae_0000, "long base disp");
    base_is_pc = 1'b0;
  endtask : t_base_disp

  task t_memory;
    base_displacement = 32'h0000_0100;
    index_register_sel = 4'h3;
    index_scale = 2'h0;
    ptr = 32'h5000_0000;
    outer_displacement = 32'h1234_fff0;
    stall = 3;
    exp_addr = 32'h2234_5778;
    go(EAG_MEM_PRE);
    chk(res, 32'h4fff_fff0, "pre-indexed result");
    outer_disp_long = 1'b1;
    outer_displacement = 32'h0000_0010;
    stall = 0;
    exp_addr = 32'h1000_0100;
    go(EAG_MEM_POST);
    chk(res, 32'h6234_5688, "post-indexed result");
  endtask : t_memory

  task t_immediate;
    ext_words = 32'h89ab_cdef;
    op_size = EAG_SIZE_BYTE;
    go(EAG_IMM);
    chk(res, 32'h0000_00ef, "byte immediate");
    op_size = EAG_SIZE_WORD;
    go(EAG_IMM);
    chk(res, 32'h0000_cdef, "word immediate");
    op_size = EAG_SIZE_LONG;
    go(EAG_IMM);
    chk(res, 32'h89ab_cdef, "long immediate");
    // absolute forms also come straight from the extension words
    go(EAG_ABS_W);
    chk(res, 32'hffff_cdef, "absolute word sign-extended");
    go(EAG_ABS_L);
    chk(res, 32'h89ab_cdef, "absolute long");
  endtask : t_immediate

  task t_update;
    // block move leaves another base selected
    address_register_sel = 3'h2;
    go(EAG_POSTINC);
    chk(res, 32'h1000_0000, "postincrement address");
    go(EAG_ADDR_DIR);
    chk(res, 32'h1000_0004, "register after increment");
    op_size = EAG_SIZE_BYTE;
    address_register_sel = 3'h7;
    go(EAG_PREDEC);
    chk(res, 32'h0000_1ffe, "stack byte predecrement");
    go(EAG_IND);
    chk(res, 32'h0000_1ffe, "register after decrement");
  endtask : t_update

  task t_move;
    address_register_sel = 3'h3;
    stall = 2;
    exp_src = 32'h0000_1230;
    exp_dst = 32'h1234_5670;
    go(EAG_BLOCK_MOVE);
  endtask : t_move

  initial begin
    nrst = 1'b0;
    req_valid = 1'b0;
    ea_mode = 4'h0;
    op_size = 2'h2;
    data_register_sel = 3'h0;
    address_register_sel = 3'h0;
    index_register_sel = 4'h0;
    index_long = 1'b0;
    index_scale = 2'h0;
    base_is_pc = 1'b0;
    program_counter = 32'h0;
    short_disp_byte = 8'h0;
    short_disp_word = 16'h0;
    base_displacement = 32'h0;
    base_disp_long = 1'b0;
    outer_displacement = 32'h0;
    outer_disp_long = 1'b0;
    ext_words = 32'h0;
    mem_rd_ack = 1'b0;
    mem_rd_data = 32'hffff_ffff;
    block_move_done = 1'b0;
    rf_wr_en = 1'b0;
    rf_wr_sel = 4'h0;
    rf_wr_data = 32'h0;
    stall = 0;
    ptr = 32'h0;
    num_errors = 0;
    num_checks = 0;
    repeat (5) @(negedge ref_clk);
    nrst = 1'b1;
    chk(32'({busy_ff, done_ff, mem_rd_req_ff, block_move_req_ff}), 32'h0, "flags after reset");
    chk(ea_result_ff, 32'h0, "result after reset");
    wr_reg(4'h3, 32'h1234_5678);
    wr_reg(4'h5, 32'h0000_8003);
    wr_reg(4'ha, 32'h1000_0000);
    wr_reg(4'hb, 32'h0000_123f);
    wr_reg(4'he, 32'hffff_fff0);
    wr_reg(4'hf, 32'h0000_2000);
    t_direct();
    t_disp();
    t_index();
    t_base_disp();
    t_memory();
    t_immediate();
    t_move();
    t_update();
    close_out();
  end

  // the whole sequence needs under a hundred cycles; the limit below is 5000 cycles
  initial begin
    #(50 * 5000);
    num_errors++;
    close_out();
  end
endmodule : test_effective_address_generator
